// ==== core/swe_core.sv ====
// Purpose: software instruction entry: entry address, frame save, flag update
// Assumes: one clock, synchronous active-high reset, classic wishbone slave
// Notes:   saved words leave on a register-stack write port, one per cycle
//
// Behaviour
// - pc gets 23 ones, zero, opcode bits 11..8, four zeros
// - five words stored ascending from frame_base plus frame_length
// - frame_length zero is treated as sixteen for save addresses and base advance, reads back as zero
// - saved pc word holds return bits 31..1 and old priv bit
// - saved status_word carries opcode_size_code one
// - frame_base advances by old frame_length, frame_length becomes six
// - cache and trace flags cleared, irq mask set, conditions kept
// - float ops are entries, not in delay slots, flags kept
// - status bits 14..13 select rounding mode
// - status bits 12..8 hold float trap enables
// - exception register: accrued bits 4..0, actual bits 12..8
// - exception register reserved bits always read zero
// - nan when exponent word bits 30..19 are all ones
// - nan bit zero clear quiet, set signaling
`timescale 1ns/10ps
module swe_core
	import swe_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             stk_we_o,
	output logic      [6:0]  stk_adr_o,
	output logic      [31:0] stk_dat_o,
	output logic      [31:0] pc_o,
	output logic      [1:0]  rounding_sel_o,
	output logic      [4:0]  fpu_trap_en_o,
	output logic             busy_o
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		swe_state_t  st;
		logic [2:0]  idx;
		logic [6:0]  frame_base;
		logic [6:0]  frame_length;
		logic [31:0] status_word;
		logic [31:0] fpu_excp_reg;
		logic [31:0] pc;
		logic        priv_bit;
		logic [31:0] opcode;
		logic [31:0] dst;
		logic [31:0] src;
		logic [31:0] src_lo;
		logic [31:0] nan_probe;
		logic [31:0] sv_pc;
		logic [31:0] sv_sw;
		swe_stk_wr_t stk;
		logic [31:0] rdat;
		logic        ack;
	} swe_st_t;

	swe_st_t s_r;
	swe_st_t s_nxt;

	logic        acc;
	logic        wr;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic [6:0]  flen_eff;
	logic        go;
	logic        is_nan;
	logic        is_snan;

	always_comb begin
		acc    = wb_cyc_i && wb_stb_i && !s_r.ack;
		wr     = acc && wb_we_i;
		wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		flen_eff = (s_r.frame_length == 7'h00) ? SWE_FLEN_ZERO : s_r.frame_length;
		go     = wr && (wb_adr_i == SWE_OFS_CTRL) && wb_dat_i[0] && wb_sel_i[0] && (s_r.st == SWE_IDLE);
		is_nan  = &s_r.nan_probe[30:19];
		is_snan = is_nan && s_r.nan_probe[0];
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt        = s_r;
		s_nxt.ack    = acc;
		s_nxt.stk.we = 1'b0;
		wval         = 32'h0000_0000;
		if (wr) begin
			if (wb_adr_i == SWE_OFS_SW) begin
				s_nxt.status_word = (s_r.status_word & ~wmask) | (wb_dat_i & wmask);
			end else if (wb_adr_i == SWE_OFS_FEXC) begin
				wval = (s_r.fpu_excp_reg & ~wmask) | (wb_dat_i & wmask);
				s_nxt.fpu_excp_reg = wval & SWE_FEXC_MASK;
			end else if (wb_adr_i == SWE_OFS_FBASE && s_r.st == SWE_IDLE) begin
				s_nxt.frame_base = wb_dat_i[6:0];
			end else if (wb_adr_i == SWE_OFS_FLEN && s_r.st == SWE_IDLE) begin
				s_nxt.frame_length = wb_dat_i[6:0];
			end else if (wb_adr_i == SWE_OFS_PC && s_r.st == SWE_IDLE) begin
				s_nxt.pc = wb_dat_i;
			end else if (wb_adr_i == SWE_OFS_OPC && s_r.st == SWE_IDLE) begin
				s_nxt.opcode = wb_dat_i;
			end else if (wb_adr_i == SWE_OFS_DST && s_r.st == SWE_IDLE) begin
				s_nxt.dst = wb_dat_i;
			end else if (wb_adr_i == SWE_OFS_SRC && s_r.st == SWE_IDLE) begin
				s_nxt.src = wb_dat_i;
			end else if (wb_adr_i == SWE_OFS_SRCLO && s_r.st == SWE_IDLE) begin
				s_nxt.src_lo = wb_dat_i;
			end else if (wb_adr_i == SWE_OFS_NAN) begin
				s_nxt.nan_probe = wb_dat_i;
			end else if (wb_adr_i == SWE_OFS_PRIV && s_r.st == SWE_IDLE) begin
				s_nxt.priv_bit = wb_dat_i[0];
			end
		end
		s_nxt.rdat = 32'h0000_0000;
		if (acc && !wb_we_i) begin
			if (wb_adr_i == SWE_OFS_STAT) begin
				s_nxt.rdat = {29'h0, is_snan, is_nan, s_r.st == SWE_SAVE};
			end else if (wb_adr_i == SWE_OFS_SW) begin
				s_nxt.rdat = s_r.status_word;
			end else if (wb_adr_i == SWE_OFS_FEXC) begin
				s_nxt.rdat = s_r.fpu_excp_reg & SWE_FEXC_MASK;
			end else if (wb_adr_i == SWE_OFS_FBASE) begin
				s_nxt.rdat = {25'h0, s_r.frame_base};
			end else if (wb_adr_i == SWE_OFS_FLEN) begin
				s_nxt.rdat = {25'h0, s_r.frame_length};
			end else if (wb_adr_i == SWE_OFS_PC) begin
				s_nxt.rdat = s_r.pc;
			end else if (wb_adr_i == SWE_OFS_OPC) begin
				s_nxt.rdat = s_r.opcode;
			end else if (wb_adr_i == SWE_OFS_DST) begin
				s_nxt.rdat = s_r.dst;
			end else if (wb_adr_i == SWE_OFS_SRC) begin
				s_nxt.rdat = s_r.src;
			end else if (wb_adr_i == SWE_OFS_SRCLO) begin
				s_nxt.rdat = s_r.src_lo;
			end else if (wb_adr_i == SWE_OFS_NAN) begin
				s_nxt.rdat = s_r.nan_probe;
			end else if (wb_adr_i == SWE_OFS_PRIV) begin
				s_nxt.rdat = {31'h0, s_r.priv_bit};
			end
		end
		case (s_r.st)
			SWE_IDLE: begin
				if (go) begin
					s_nxt.st    = SWE_SAVE;
					s_nxt.idx   = 3'h0;
					s_nxt.sv_pc = {s_r.pc[31:1], s_r.priv_bit};
					s_nxt.sv_sw = s_r.status_word;
					s_nxt.sv_sw[SWE_OSC_HI:SWE_OSC_LO] = SWE_OSC_SOFT;
					s_nxt.pc = {SWE_ENTRY_HI, 1'b0, s_r.opcode[11:8], 4'h0};
					s_nxt.status_word[SWE_BIT_CACHE] = 1'b0;
					s_nxt.status_word[SWE_BIT_TRACE] = 1'b0;
					s_nxt.status_word[SWE_BIT_IRQM]  = 1'b1;
				end
			end
			SWE_SAVE: begin
				s_nxt.stk.we  = 1'b1;
				s_nxt.stk.adr = s_r.frame_base + flen_eff + {4'h0, s_r.idx};
				case (s_r.idx)
					3'h0: s_nxt.stk.dat = s_r.dst;
					3'h1: s_nxt.stk.dat = s_r.src;
					3'h2: s_nxt.stk.dat = s_r.src_lo;
					3'h3: s_nxt.stk.dat = s_r.sv_pc;
					default: s_nxt.stk.dat = s_r.sv_sw;
				endcase
				s_nxt.idx = s_r.idx + 3'h1;
				if (s_r.idx == SWE_NWORDS - 3'h1) begin
					s_nxt.st           = SWE_IDLE;
					s_nxt.frame_base   = s_r.frame_base + flen_eff;
					s_nxt.frame_length = SWE_FLEN_NEW;
				end
			end
			default: s_nxt.st = SWE_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r              <= '0;
			s_r.st           <= SWE_IDLE;
			s_r.status_word  <= SWE_SW_RST;
			s_r.frame_base   <= SWE_FBASE_RST;
			s_r.frame_length <= SWE_FLEN_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	always_comb begin
		wb_ack_o       = s_r.ack;
		wb_dat_o       = s_r.rdat;
		stk_we_o       = s_r.stk.we;
		stk_adr_o      = s_r.stk.adr;
		stk_dat_o      = s_r.stk.dat;
		pc_o           = s_r.pc;
		rounding_sel_o = s_r.status_word[SWE_RND_HI:SWE_RND_LO];
		fpu_trap_en_o  = s_r.status_word[SWE_TRAP_HI:SWE_TRAP_LO];
		busy_o         = (s_r.st == SWE_SAVE);
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence seq_go;
		go;
	endsequence

	sequence seq_five_writes;
		stk_we_o [*5];
	endsequence

	a_entry_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		go |=> pc_o == {23'h7F_FFFF, 1'b0, $past(s_r.opcode[11:8]), 4'h0})
		else $error("entry address wrong");

	a_save_seq: assert property (@(posedge clk_i) disable iff (rst_i)
		seq_go |-> ##2 seq_five_writes ##1 !stk_we_o)
		else $error("save sequence not five words");

	a_first_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		go |-> ##2 stk_adr_o == $past(s_r.frame_base, 2) + ($past(s_r.frame_length, 2) == 7'h00 ?
			7'h10 : $past(s_r.frame_length, 2)))
		else $error("first save address wrong");

	a_saved_pc: assert property (@(posedge clk_i) disable iff (rst_i)
		go |-> ##5 stk_dat_o == {$past(s_r.pc[31:1], 5), $past(s_r.priv_bit, 5)})
		else $error("saved pc word wrong");

	a_saved_size: assert property (@(posedge clk_i) disable iff (rst_i)
		go |-> ##6 stk_dat_o[20:19] == 2'h1)
		else $error("saved size code not one");

	a_new_frame: assert property (@(posedge clk_i) disable iff (rst_i)
		go |-> ##6 s_r.frame_length == 7'h06)
		else $error("frame length not six");

	a_mode_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		go |=> s_r.status_word[15] && !s_r.status_word[21] && !s_r.status_word[16])
		else $error("mode flags wrong on entry");

	a_round_sel: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && wb_adr_i == SWE_OFS_SW && wb_sel_i[1]) |=> rounding_sel_o == $past(wb_dat_i[14:13]))
		else $error("rounding select mismatch");

	a_trap_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && wb_adr_i == SWE_OFS_SW && wb_sel_i[1]) |=> fpu_trap_en_o == $past(wb_dat_i[12:8]))
		else $error("trap enables mismatch");

	a_fexc_resv: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.fpu_excp_reg[31:13] == 19'h0) && (s_r.fpu_excp_reg[7:5] == 3'h0))
		else $error("reserved exception bits set");

	a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

	a_wb_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("request not answered next cycle");

endmodule

// ==== core/swe_pkg.sv ====
// Purpose: shared constants and types for the software instruction entry block
// Assumes: 32-bit words, register stack addressed in words
// Notes:   register offsets are byte addresses on the wishbone slave
package swe_pkg;
	localparam logic [7:0]  SWE_OFS_CTRL   = 8'h00;
	localparam logic [7:0]  SWE_OFS_STAT   = 8'h04;
	localparam logic [7:0]  SWE_OFS_SW     = 8'h08;
	localparam logic [7:0]  SWE_OFS_FEXC   = 8'h0C;
	localparam logic [7:0]  SWE_OFS_FBASE  = 8'h10;
	localparam logic [7:0]  SWE_OFS_FLEN   = 8'h14;
	localparam logic [7:0]  SWE_OFS_PC     = 8'h18;
	localparam logic [7:0]  SWE_OFS_OPC    = 8'h1C;
	localparam logic [7:0]  SWE_OFS_DST    = 8'h20;
	localparam logic [7:0]  SWE_OFS_SRC    = 8'h24;
	localparam logic [7:0]  SWE_OFS_SRCLO  = 8'h28;
	localparam logic [7:0]  SWE_OFS_NAN    = 8'h2C;
	localparam logic [7:0]  SWE_OFS_PRIV   = 8'h30;
	localparam logic [31:0] SWE_SW_RST     = 32'h0000_0000;
	localparam logic [31:0] SWE_FEXC_MASK  = 32'h0000_1F1F;
	localparam logic [22:0] SWE_ENTRY_HI   = 23'h7F_FFFF;
	localparam logic [6:0]  SWE_FLEN_ZERO  = 7'h10;
	localparam logic [6:0]  SWE_FLEN_NEW   = 7'h06;
	localparam logic [2:0]  SWE_NWORDS     = 3'h5;
	localparam logic [1:0]  SWE_OSC_SOFT   = 2'h1;
	localparam int          SWE_RND_HI     = 14;
	localparam int          SWE_RND_LO     = 13;
	localparam int          SWE_TRAP_HI    = 12;
	localparam int          SWE_TRAP_LO    = 8;
	localparam int          SWE_OSC_HI     = 20;
	localparam int          SWE_OSC_LO     = 19;
	localparam int          SWE_BIT_CACHE  = 21;
	localparam int          SWE_BIT_TRACE  = 16;
	localparam int          SWE_BIT_IRQM   = 15;
	localparam logic [6:0]  SWE_FLEN_RST   = 7'h00;
	localparam logic [6:0]  SWE_FBASE_RST  = 7'h00;

	typedef enum logic [1:0] {
		SWE_RND_NEAREST,
		SWE_RND_ZERO,
		SWE_RND_NEG_INF,
		SWE_RND_POS_INF
	} swe_rnd_t;

	typedef enum {
		SWE_IDLE,
		SWE_SAVE
	} swe_state_t;

	typedef struct packed {
		logic [31:0] dat;
		logic [7:0]  adr;
		logic        we;
		logic        cyc;
		logic        stb;
	} swe_wb_req_t;

	typedef struct packed {
		logic        we;
		logic [6:0]  adr;
		logic [31:0] dat;
	} swe_stk_wr_t;
endpackage

// ==== dv/tb_software_instruction_entry.sv ====
// Purpose: self-checking bench for the software instruction entry block
// Assumes: one-cycle registered ack, five stack writes per entry
// Notes:   expected values are built from the entry and encoding figures
`timescale 1ns/10ps
module tb_software_instruction_entry;
	import swe_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	swe_wb_req_t req   = '0;
	logic [3:0]  sel   = 4'hF;
	logic [31:0] wb_dat_o, stk_dat_o, pc_o, q;
	logic        wb_ack_o, stk_we_o, busy_o;
	logic [6:0]  stk_adr_o;
	logic [1:0]  rounding_sel_o;
	logic [4:0]  fpu_trap_en_o;
	logic [38:0] stk_q[$];
	int          fail_count = 0;
	int          n_tests    = 0;
	logic [31:0] nan_w[4] = '{32'h7FF8_0000, 32'hFFFF_FFFF, 32'h7FF7_FFFF, 32'h3FF8_0001};
	logic [31:0] nan_s[4] = '{32'h2, 32'h6, 32'h0, 32'h0};

	always #4 clk_i = ~clk_i;

	swe_core u_swe_core (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
		.wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(sel), .wb_dat_i(req.dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stk_we_o(stk_we_o),
		.stk_adr_o(stk_adr_o), .stk_dat_o(stk_dat_o), .pc_o(pc_o),
		.rounding_sel_o(rounding_sel_o), .fpu_trap_en_o(fpu_trap_en_o), .busy_o(busy_o)
	);

	always @(posedge clk_i) begin
		if (stk_we_o === 1'b1) stk_q.push_back({stk_adr_o, stk_dat_o});
	end

	////////////////////////////////////////////////////////////
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task end_sim;
		$display("checks %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= '{d, a, we, 1'b1, 1'b1};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		q = wb_dat_o;
		req <= '0;
		if (n >= 16) begin
			fail_count++;
			end_sim();
		end
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		wb(1'b0, a, 32'h0);
		chk(what, exp, q);
	endtask

	task settle;
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	task entry(input logic [6:0] fbase, input logic [6:0] flen, input logic [3:0] op,
		input logic [31:0] pcv, input logic [31:0] sw);
		logic [6:0]  base;
		logic [31:0] exp[5];
		logic [31:0] m;
		int          n;
		base = fbase + ((flen == 7'h0) ? SWE_FLEN_ZERO : flen);
		exp  = '{32'h11 + op, 32'h22 + op, 32'h33 + op, {pcv[31:1], op[0]}, {sw[31:21], SWE_OSC_SOFT, sw[18:0]}};
		m    = 32'h0018_0000;
		wb(1'b1, SWE_OFS_FBASE, 32'(fbase));
		wb(1'b1, SWE_OFS_FLEN, 32'(flen));
		wb(1'b1, SWE_OFS_PC, pcv);
		wb(1'b1, SWE_OFS_PRIV, 32'(op[0]));
		wb(1'b1, SWE_OFS_OPC, {20'h0, op, 8'h0});
		wb(1'b1, SWE_OFS_DST, exp[0]);
		wb(1'b1, SWE_OFS_SRC, exp[1]);
		wb(1'b1, SWE_OFS_SRCLO, exp[2]);
		wb(1'b1, SWE_OFS_SW, sw);
		stk_q.delete();
		wb(1'b1, SWE_OFS_CTRL, 32'h1);
		wb(1'b1, SWE_OFS_FBASE, 32'h7F);
		chk("busy", 32'h1, 32'(busy_o));
		n = 0;
		while (busy_o !== 1'b0 && n < 32) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 32) begin
			fail_count++;
			end_sim();
		end
		settle();
		chk("stack count", 32'h5, 32'(stk_q.size()));
		for (int k = 0; k < stk_q.size() && k < 5; k++) begin
			chk("stack adr", 32'(7'(base + 7'(k))), 32'(stk_q[k][38:32]));
			chk("stack data", exp[k], stk_q[k][31:0]);
		end
		chk("pc", {SWE_ENTRY_HI, 1'b0, op, 4'h0}, pc_o);
		rd(SWE_OFS_FBASE, 32'(base), "frame base advance");
		rd(SWE_OFS_FLEN, 32'(SWE_FLEN_NEW), "frame length six");
		wb(1'b0, SWE_OFS_SW, 32'h0);
		chk("sw flags", ((sw & ~(32'h1 << SWE_BIT_CACHE) & ~(32'h1 << SWE_BIT_TRACE))
			| (32'h1 << SWE_BIT_IRQM)) & ~m, q & ~m);
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(SWE_OFS_SW, SWE_SW_RST, "sw reset");
		rd(SWE_OFS_FBASE, 32'(SWE_FBASE_RST), "frame base reset");
		rd(SWE_OFS_FLEN, 32'(SWE_FLEN_RST), "frame length reset");
		wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
		rd(8'h3C, 32'h0, "unmapped");
		wb(1'b1, SWE_OFS_FEXC, 32'hFFFF_FFFF);
		rd(SWE_OFS_FEXC, SWE_FEXC_MASK, "fexc reserved");
		sel <= 4'h1;
		wb(1'b1, SWE_OFS_FEXC, 32'h0);
		sel <= 4'hF;
		rd(SWE_OFS_FEXC, 32'h0000_1F00, "fexc lanes");
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, SWE_OFS_SW, {17'h0, i[1:0], 5'(5'h1 << i), 8'h0});
			settle();
			chk("rounding", 32'(i[1:0]), 32'(rounding_sel_o));
			chk("trap enables", 32'(5'(5'h1 << i)), 32'(fpu_trap_en_o));
		end
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, SWE_OFS_NAN, nan_w[i]);
			rd(SWE_OFS_STAT, nan_s[i], "nan probe");
		end
		entry(7'h10, 7'h00, 4'hA, 32'h1234_5679, 32'h0033_600F);
		entry(7'h7C, 7'h06, 4'h5, 32'h8000_0002, 32'h0031_8000);
		end_sim();
	end
endmodule
